// [src/uss_pkg.sv]
// Purpose: Shared constants and types for the universal shift unit
// Assumes: Control, status and data access arrive as plain ports
// Notes:   Field positions refer to the control and status port vectors
package uss_pkg;

  // Control vector layout
  localparam int CR_WIDTH       = 8;
  localparam int CR_WM_HI       = 5;   // Wire mode, high bit
  localparam int CR_WM_LO       = 4;   // Wire mode, low bit
  localparam int CR_CS_HI       = 3;   // Clock source select, high bit
  localparam int CR_CS_LO       = 2;   // External clock edge select
  localparam int CR_CLK_STROBE  = 1;   // Count on software strobe
  localparam int CR_TOGGLE      = 0;   // Clock toggle strobe

  // Status vector layout
  localparam int SR_START_FLAG  = 7;
  localparam int SR_OVF_FLAG    = 6;
  localparam int SR_CNT_HI      = 3;

  // Wire modes
  localparam logic [1:0] WM_OFF   = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO   = 2'h2;
  localparam logic [1:0] WM_TWOH  = 2'h3;

  // Reset values and counter top value
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST  = 4'h0;
  localparam logic [3:0] CNT_MAX  = 4'hF;

  // Edge/sampling kind
  typedef enum logic [1:0] {
    USS_EDGE_NONE,
    USS_EDGE_RISE,
    USS_EDGE_FALL
  } uss_edge_type;

endpackage : uss_pkg

// [src/uss_edge_sync.sv]
// Purpose: Two-stage synchroniser with edge detection for a pin input
// Assumes: Input is asynchronous to sys_clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module uss_edge_sync
  import uss_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          pin_i,
  output logic               level_o,
  output uss_pkg::uss_edge_type edge_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } uss_sync_state_type;

  uss_sync_state_type st_q;
  uss_sync_state_type st_d;

  // Shift chain
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edge decode from the settled stages only
  always_comb begin
    level_o = st_q.s2;
    if (st_q.s2 && !st_q.s3) begin
      edge_o = USS_EDGE_RISE;
    end else if (!st_q.s2 && st_q.s3) begin
      edge_o = USS_EDGE_FALL;
    end else begin
      edge_o = USS_EDGE_NONE;
    end
  end

endmodule : uss_edge_sync

// [src/uss_shift_unit.sv]
// Purpose: Universal serial shift unit: 8-bit shift register, 4-bit counter
// Assumes: Software access via plain write strobes; pins sampled into sys_clk_i
// Notes:   Three-wire mode is the main use; two-wire hold hooks included
`timescale 1ns/1ps
module uss_shift_unit
  import uss_pkg::*;
(
  input  wire logic                      sys_clk_i,
  input  wire logic                      nrst_i,
  // Software access
  input  wire logic                      data_wr_i,
  input  wire logic [7:0]                data_wdata_i,
  output logic      [7:0]                data_rdata_o,
  input  wire logic                      ctrl_wr_i,
  input  wire logic [uss_pkg::CR_WIDTH-1:0] ctrl_wdata_i,
  output logic      [uss_pkg::CR_WIDTH-1:0] ctrl_rdata_o,
  input  wire logic                      stat_wr_i,
  input  wire logic [7:0]                stat_wdata_i,
  output logic      [7:0]                stat_rdata_o,
  // Events
  input  wire logic                      timer_match_i,
  output logic                           ovf_wake_o,
  output logic                           start_irq_o,
  // Pins
  input  wire logic                      serial_in_pin_i,
  output logic                           data_out_pin_o,
  input  wire logic                      serial_clock_pin_i,
  output logic                           serial_clock_pin_o,
  output logic                           serial_clock_pin_oe_o,
  output logic                           sda_pin_o,
  output logic                           sda_pin_oe_o
);

  typedef struct packed {
    logic [7:0]                 shreg;
    logic [3:0]                 cnt;
    logic                       ovf;
    logic                       start;
    logic                       out_latch;
    logic [CR_WIDTH-1:0]        ctrl;
    logic                       clk_out;
    logic                       sin_s1;
    logic                       sin_s2;
    logic                       hold_low;
  } uss_state_type;

  uss_state_type st_q;
  uss_state_type st_d;

  logic         clk_lvl;
  uss_edge_type clk_edge;
  logic         sda_lvl;
  uss_edge_type sda_edge;

  // Synchronise serial clock pin and find its edges
  uss_edge_sync u_clk_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (serial_clock_pin_i),
    .level_o   (clk_lvl),
    .edge_o    (clk_edge)
  );

  // Two-wire data line watched for start conditions
  uss_edge_sync u_sda_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (serial_in_pin_i),
    .level_o   (sda_lvl),
    .edge_o    (sda_edge)
  );

  logic [1:0] wmode;
  logic       cs_hi;
  logic       edge_sel;
  logic       strobe_cnt;
  logic       samp_evt;
  logic       shift_evt;
  logic       cnt_evt;
  logic       toggle_wr;
  logic       sin_bit;

  always_comb begin
    wmode      = st_q.ctrl[CR_WM_HI:CR_WM_LO];
    cs_hi      = st_q.ctrl[CR_CS_HI];
    edge_sel   = st_q.ctrl[CR_CS_LO];
    strobe_cnt = st_q.ctrl[CR_CLK_STROBE];
    toggle_wr  = ctrl_wr_i && ctrl_wdata_i[CR_TOGGLE];
    sin_bit    = st_q.sin_s2;
    samp_evt   = 1'b0;
    shift_evt  = 1'b0;
    cnt_evt    = 1'b0;
    // Clock source choice
    if (!cs_hi) begin
      // Internal, edge select clear: timer match or software strobe shifts one whole bit; edge select set blocks both
      samp_evt = edge_sel ? 1'b0 : (timer_match_i || (ctrl_wr_i && ctrl_wdata_i[CR_CLK_STROBE]));
      cnt_evt  = samp_evt;
    end else begin
      // External pin: edge select picks sampling edge
      samp_evt  = edge_sel ? (clk_edge == USS_EDGE_FALL)
                           : (clk_edge == USS_EDGE_RISE);
      shift_evt = edge_sel ? (clk_edge == USS_EDGE_RISE)
                           : (clk_edge == USS_EDGE_FALL);
      // Both edges counted, or strobe counting when selected
      cnt_evt   = strobe_cnt ? toggle_wr
                             : (clk_edge != USS_EDGE_NONE);
    end
  end

  // Next-state logic
  always_comb begin
    st_d        = st_q;
    st_d.sin_s1 = serial_in_pin_i;
    st_d.sin_s2 = st_q.sin_s1;
    if (ctrl_wr_i) begin
      st_d.ctrl = ctrl_wdata_i;
      st_d.ctrl[CR_TOGGLE] = 1'b0;                                     // Strobe reads zero
    end
    // Toggle strobe flips the driven clock level
    if (toggle_wr) begin
      st_d.clk_out = !st_q.clk_out;
    end
    // Sample into lsb; shift register holds all data with no buffer
    if (samp_evt) begin
      st_d.shreg = {st_q.shreg[6:0], sin_bit};
    end
    // Internal clocking: latch takes the new msb in the same cycle as the bit shift
    if (!cs_hi && samp_evt) begin
      st_d.out_latch = st_q.shreg[6];
    end
    // External clocking: latch opens on the opposite edge
    if (cs_hi && shift_evt) begin
      st_d.out_latch = st_q.shreg[7];
    end
    if (data_wr_i) begin
      st_d.shreg     = data_wdata_i;
      st_d.out_latch = data_wdata_i[7];
    end
    // Counter with wrap and sticky overflow
    if (cnt_evt) begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
    if (stat_wr_i) begin
      st_d.cnt = stat_wdata_i[SR_CNT_HI:0];
      if (stat_wdata_i[SR_OVF_FLAG]) st_d.ovf = 1'b0;
      if (stat_wdata_i[SR_START_FLAG]) st_d.start = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (cnt_evt && st_q.cnt == CNT_MAX && !stat_wr_i) begin
      st_d.ovf = 1'b1;
    end else if (cnt_evt && st_q.cnt == CNT_MAX) begin
      st_d.ovf = 1'b1;
    end
    // Start condition: data falls while clock high in two-wire mode
    if (wmode[1] && sda_edge == USS_EDGE_FALL && clk_lvl) begin
      st_d.start = 1'b1;
    end
    // Wait states: hold clock low after start in two-wire mode, or after overflow in WM_TWOH mode only
    st_d.hold_low = wmode[1] &&
                    ((st_d.start && !clk_lvl) || (wmode == WM_TWOH && st_d.ovf));
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  always_comb begin
    data_rdata_o          = st_q.shreg;
    ctrl_rdata_o          = st_q.ctrl;
    stat_rdata_o          = {st_q.start, st_q.ovf, 2'b00, st_q.cnt};
    ovf_wake_o            = st_q.ovf;
    start_irq_o           = st_q.start;
    data_out_pin_o        = (wmode == WM_THREE) ? st_q.out_latch : 1'b0;
    sda_pin_o             = 1'b0;
    sda_pin_oe_o          = !(wmode[1] && !st_q.out_latch);
    serial_clock_pin_o    = st_q.hold_low ? 1'b0 : st_q.clk_out;
    serial_clock_pin_oe_o = !(st_q.hold_low || (wmode == WM_THREE && !cs_hi) ||
                              (strobe_cnt && cs_hi && wmode == WM_THREE));
  end

endmodule : uss_shift_unit

// [dv/uss_chk_sva.sv]
// Purpose: Port assertions for the shift unit
// Assumes: Single sys_clk_i domain
// Notes:   Bound into every uss_shift_unit
`timescale 1ns/1ps
module uss_chk
  import uss_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 nrst_i,
  input wire logic                 data_wr_i,
  input wire logic [7:0]           data_wdata_i,
  input wire logic [7:0]           data_rdata_o,
  input wire logic                 ctrl_wr_i,
  input wire logic [CR_WIDTH-1:0]  ctrl_wdata_i,
  input wire logic [CR_WIDTH-1:0]  ctrl_rdata_o,
  input wire logic                 stat_wr_i,
  input wire logic [7:0]           stat_wdata_i,
  input wire logic [7:0]           stat_rdata_o,
  input wire logic                 ovf_wake_o,
  input wire logic                 sda_pin_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Count steps from the top to zero without a status write
  sequence s_wrap;
    stat_rdata_o[3:0] == CNT_MAX && !stat_wr_i ##1 stat_rdata_o[3:0] == CNT_RST;
  endsequence
  property p_rd; data_wr_i |=> data_rdata_o == $past(data_wdata_i); endproperty
  a_rd: assert property (p_rd) else $error("shift data readback wrong");
  property p_ctl; ctrl_wr_i |=> ctrl_rdata_o == ($past(ctrl_wdata_i) & 8'hFE); endproperty
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  property p_ld; stat_wr_i |=> {4'h0, stat_rdata_o[3:0]} == ($past(stat_wdata_i) & 8'h0F);
  endproperty
  a_ld: assert property (p_ld) else $error("counter load wrong");
  // A wrap in the same cycle sets the flag again, so only check off the top count
  property p_clr;
    stat_wr_i && stat_wdata_i[SR_OVF_FLAG] && stat_rdata_o[3:0] != CNT_MAX |=> !ovf_wake_o;
  endproperty
  a_clr: assert property (p_clr) else $error("overflow flag not cleared");
  property p_hold; ovf_wake_o && !stat_wr_i |=> ovf_wake_o; endproperty
  a_hold: assert property (p_hold) else $error("overflow flag dropped");
  property p_set; s_wrap |-> ovf_wake_o; endproperty
  a_set: assert property (p_set) else $error("wrap without overflow flag");
  property p_mir; ovf_wake_o == stat_rdata_o[SR_OVF_FLAG]; endproperty
  a_mir: assert property (p_mir) else $error("wake and status flag differ");
  property p_sda; ctrl_rdata_o[5:4] == WM_THREE |-> sda_pin_oe_o; endproperty
  a_sda: assert property (p_sda) else $error("two-wire data pin driven");
endmodule : uss_chk
bind uss_shift_unit uss_chk uss_chk_inst (.*);

// [dv/uss_spi_master_model.sv]
// Purpose: Behavioural SPI master facing the shift unit pins
// Assumes: Clock idles low, 80 ns period
// Notes:   Data line flips after each frame
`timescale 1ns/1ps
module uss_spi_master_model (
  input  wire logic       go_i,
  input  wire logic       mode_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       miso_i,
  output logic            sck_o,
  output logic            mosi_o,
  output logic [7:0]      rx_o,
  output logic            done_o
);
  // Idle line levels
  initial begin
    {sck_o, mosi_o, rx_o, done_o} = 11'h200;
  end
  // One frame of eight pulses, msb first
  always @(posedge go_i) begin
    done_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!mode_i) mosi_o = tx_i[i];
      #40 sck_o = 1'b1;
      if (mode_i) mosi_o = tx_i[i];
      else rx_o = {rx_o[6:0], miso_i};
      #40 sck_o = 1'b0;
      if (mode_i) rx_o = {rx_o[6:0], miso_i};
    end
    #40 mosi_o = ~mosi_o;
    done_o = 1'b1;
  end
endmodule : uss_spi_master_model

// [dv/testbench.sv]
// Purpose: Self-checking bench for the shift unit
// Assumes: Partner model acts as SPI master
// Notes:   Timer match drives the internal clock
`timescale 1ns/1ps
module testbench;
  import uss_pkg::*;
  logic       sys_clk = 0, nrst_n = 0, dwr = 0, cwr = 0, swr = 0, tm = 0;
  logic       go = 0, mode = 0, hold_in = 0;
  logic [7:0] wd = 8'h00, mtx = 8'h00, data_rd, ctrl_rd, stat_rd, mrx;
  logic       sck, mosi, miso, mdone, sck_oe, sda_oe;
  logic       ovf, sirq, sclk, sda_o, clk_hi = 0, sda_low = 0;
  int         fail_count = 0, compares = 0;
  // System clock
  always #2.5 sys_clk = ~sys_clk;
  uss_shift_unit uss_shift_unit_inst (.sys_clk_i(sys_clk), .nrst_i(nrst_n),
    .data_wr_i(dwr), .data_wdata_i(wd), .data_rdata_o(data_rd), .ctrl_wr_i(cwr),
    .ctrl_wdata_i(wd), .ctrl_rdata_o(ctrl_rd), .stat_wr_i(swr), .stat_wdata_i(wd),
    .stat_rdata_o(stat_rd), .timer_match_i(tm), .ovf_wake_o(ovf), .start_irq_o(sirq),
    .serial_in_pin_i((hold_in | mosi) & ~sda_low), .data_out_pin_o(miso),
    .serial_clock_pin_i(sck | clk_hi),
    .serial_clock_pin_o(sclk), .serial_clock_pin_oe_o(sck_oe), .sda_pin_o(sda_o),
    .sda_pin_oe_o(sda_oe));
  uss_spi_master_model uss_spi_master_model_inst (.go_i(go), .mode_i(mode), .tx_i(mtx),
    .miso_i(miso), .sck_o(sck), .mosi_o(mosi), .rx_o(mrx), .done_o(mdone));
  // One write strobe: 0 data, 1 control, 2 status
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge sys_clk);
    wd <= v;
    {dwr, cwr, swr} <= {k == 0, k == 1, k == 2};
    @(posedge sys_clk);
    {dwr, cwr, swr} <= 3'h0;
  endtask : wr
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Values straight after reset
  task automatic t_reset;
    chk("data", DATA_RST, data_rd);
    chk("status", 8'h00, stat_rd);
    chk("oe", 8'h03, {6'h00, sck_oe, sda_oe});
  endtask : t_reset
  // Full byte exchange with the external master
  task automatic t_spi(input logic m, input logic [7:0] dv, input logic [7:0] mv);
    int n;
    n = 0;
    wr(1, m ? 8'h1C : 8'h18);
    wr(0, dv);
    wr(2, 8'h40);
    {mode, mtx, go} <= {m, mv, 1'b1};
    @(posedge sys_clk);
    go <= 1'b0;
    while (mdone !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 400) begin
      fail_count++;
      report_and_stop();
    end
    repeat (6) @(negedge sys_clk);
    chk("ctrl", m ? 8'h1C : 8'h18, ctrl_rd);
    chk("rx", mv, data_rd);
    chk("tx", dv, mrx);
    chk("status", 8'h40, stat_rd);
    chk("wake", 8'h01, {7'h00, ovf});
  endtask : t_spi
  // Internal shifting by timer compare matches
  task automatic t_timer;
    wr(1, 8'h10);
    wr(0, 8'h00);
    hold_in <= 1'b1;
    wr(2, 8'h48);
    @(negedge sys_clk);
    chk("count", 8'h08, stat_rd);
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      if (i == 4) chk("mid", 8'h0F, data_rd);
      @(posedge sys_clk);
      tm <= 1'b1;
      @(posedge sys_clk);
      tm <= 1'b0;
    end
    repeat (2) @(negedge sys_clk);
    chk("shift", 8'hFF, data_rd);
    chk("wrap", 8'h40, stat_rd);
    wr(2, 8'h45);
    @(negedge sys_clk);
    chk("clear", 8'h05, stat_rd);
  endtask : t_timer
  // Two-wire start detection, clock hold and open-drain data drive
  task automatic t_two_wire;
    wr(1, 8'h20);
    clk_hi <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_low <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("start", 8'h85, stat_rd);
    chk("start irq", 8'h01, {7'h00, sirq});
    chk("released", 8'h01, {6'h00, sclk, sck_oe});
    @(posedge sys_clk);
    clk_hi <= 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("held", 8'h00, {6'h00, sclk, sck_oe});
    wr(2, 8'h80);
    @(negedge sys_clk);
    chk("unheld", 8'h01, {6'h00, sclk, sck_oe});
    chk("start clr", 8'h00, stat_rd);
    wr(0, 8'h00);
    @(negedge sys_clk);
    chk("sda drive", 8'h00, {6'h00, sda_o, sda_oe});
    wr(0, 8'h80);
    @(negedge sys_clk);
    chk("sda release", 8'h01, {6'h00, sda_o, sda_oe});
    @(posedge sys_clk);
    sda_low <= 1'b0;
  endtask : t_two_wire
  // Software strobe shifting, strobe counting and clock toggle
  task automatic t_strobe;
    wr(0, 8'h81);
    wr(2, 8'h40);
    wr(1, 8'h12);
    @(negedge sys_clk);
    chk("strobe shift", 8'h03, data_rd);
    chk("strobe count", 8'h01, stat_rd);
    wr(1, 8'h11);
    @(negedge sys_clk);
    chk("toggle", 8'h02, {6'h00, sclk, sck_oe});
    chk("toggle rd", 8'h10, ctrl_rd);
    wr(1, 8'h18);
    wr(1, 8'h1A);
    wr(1, 8'h1B);
    wr(1, 8'h1B);
    @(negedge sys_clk);
    chk("strobe edges", 8'h03, stat_rd);
    chk("master clock", 8'h02, {6'h00, sclk, sck_oe});
    chk("no shift", 8'h03, data_rd);
  endtask : t_strobe
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_spi(1'b0, 8'hA5, 8'h3C);
    t_spi(1'b1, 8'h96, 8'h5A);
    t_timer();
    t_two_wire();
    t_strobe();
    report_and_stop();
  end
endmodule : testbench
